// *** design/icseq_brg.sv ***
`timescale 1ns/1ns
module icseq_brg (
    // Clock and reset.
    input  wire logic                           clk_sys,
    input  wire logic                           rst_b,
    // Control.
    input  wire logic                           load,
    input  wire logic [icseq_pkg::RATE_W-1:0]   load_val,
    input  wire logic                           off,
    // Status.
    output logic      [icseq_pkg::RATE_W-1:0]   cnt_o,
    output logic                                run_o,
    output logic                                tmo_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Down counter; a timeout is one cycle at zero, then the counter stops.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_o <= icseq_pkg::CNT_RST;
            run_o <= 1'b0;
        end else if (load) begin
            cnt_o <= load_val;
            run_o <= 1'b1;
        end else if (off) begin
            run_o <= 1'b0;
        end else if (run_o) begin
            if (cnt_o == icseq_pkg::CNT_RST) begin
                run_o <= 1'b0;
            end else begin
                cnt_o <= cnt_o - 7'h01;
            end
        end
    end

    assign tmo_o = run_o && (cnt_o == icseq_pkg::CNT_RST);

endmodule

// *** design/icseq_core.sv ***
`timescale 1ns/1ns
// Overview of operation
// - Restart begins only from idle or hold; first SCL is driven low.
// - With SCL seen low, counter loads reload bits five to zero.
// - SDA released one rate period; SCL released then only if SDA high.
// - With SCL seen high, reload seven bits; both lines must stay high.
// - SDA held low one period, then restart bit clears, SDA stays low.
// - Start detect sets at once; event flag waits for counter timeout.
// - A restart request during another bus event is ignored.
// - Collision if SDA low as SCL rises, or SCL falls early.
// - Buffer write during restart sets write collision, buffer unchanged.
// - Low five control bits are write-locked while a sequence runs.
// - Acknowledge request pulls SCL low and drives the ack value.
// - Ack: one period low, release SCL, wait high, one period, low.
// - Ack end clears its request, stops the counter, returns idle.
// - Buffer write during acknowledge sets write collision, is dropped.
// - After a byte SCL is held low until a stop, restart or acknowledge request.
// - Stop: SDA low, count, release SCL, one period later release SDA.
// - Stop detect on SDA high with SCL high; period later event flag.
// - Buffer write during stop sets write collision, buffer unchanged.
module icseq_core (
    // Clock and reset.
    input  wire logic                                clk_sys,
    input  wire logic                                rst_b,
    // Software control.
    input  wire logic                                ctl_wr,
    input  wire logic [icseq_pkg::CTL_W-1:0]         ctl_wdata,
    input  wire logic                                ack_value_bit,
    input  wire logic [icseq_pkg::RATE_W-1:0]        rate_reload_value,
    input  wire logic                                buf_wr,
    input  wire logic [icseq_pkg::BUF_W-1:0]         buf_wdata,
    input  wire logic                                event_clr,
    input  wire logic                                write_collision_flag_clr,
    input  wire logic                                coll_clr,
    // Byte engine handshake.
    input  wire logic                                xfer_busy,
    input  wire logic                                byte_done,
    // Bus lines.
    input  wire logic                                scl_i,
    input  wire logic                                sda_i,
    output icseq_pkg::icseq_pin_t                    pin_r,
    // Software status.
    output logic      [icseq_pkg::CTL_W-1:0]         serial_control_two_r,
    output icseq_pkg::icseq_stat_t                   stat_r,
    output logic      [icseq_pkg::BUF_W-1:0]         shift_buffer_r
);

    icseq_pkg::icseq_state_t state_r;
    icseq_pkg::icseq_state_t state_nxt;
    icseq_pkg::icseq_pin_t   pin_nxt;
    logic [icseq_pkg::PIN_N-1:0]  lvl;
    logic                         scl_s;
    logic                         sda_s;
    logic                         sda_prev_r;
    logic                         scl_prev_r;
    logic                         free;
    logic                         busy;
    logic                         go_rs;
    logic                         go_sp;
    logic                         go_ack;
    logic                         ld;
    logic [icseq_pkg::RATE_W-1:0] ld_val;
    logic                         off;
    logic [icseq_pkg::RATE_W-1:0] brg_cnt;
    logic                         brg_run;
    logic                         brg_tmo;
    logic                         coll_set;
    logic                         evt_set;
    logic [icseq_pkg::CTL_W-1:0]  clr_mask;
    logic                         start_seen;
    logic                         stop_seen;

    ////////////////////////////////////////////////////////////////////////////
    // Line synchroniser and rate counter.
    icseq_sync icseq_sync_inst (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .line_i  ({scl_i, sda_i}),
        .lvl_o   (lvl)
    );
    assign scl_s = lvl[1];
    assign sda_s = lvl[0];
    icseq_brg icseq_brg_inst (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .load     (ld),
        .load_val (ld_val),
        .off      (off),
        .cnt_o    (brg_cnt),
        .run_o    (brg_run),
        .tmo_o    (brg_tmo)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request acceptance.
    assign free   = ((state_r == icseq_pkg::ST_IDLE) || (state_r == icseq_pkg::ST_HOLD)) && !xfer_busy;
    assign busy   = (state_r != icseq_pkg::ST_IDLE) && (state_r != icseq_pkg::ST_HOLD);
    assign go_rs  = ctl_wr && free && ctl_wdata[icseq_pkg::CTL_RESTART];
    assign go_sp  = ctl_wr && free && ctl_wdata[icseq_pkg::CTL_STOP];
    assign go_ack = ctl_wr && free && ctl_wdata[icseq_pkg::CTL_ACK];
    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state.
    always_comb begin
        state_nxt = state_r;
        pin_nxt   = pin_r;
        ld        = 1'b0;
        ld_val    = rate_reload_value;
        off       = 1'b0;
        coll_set  = 1'b0;
        evt_set   = 1'b0;
        clr_mask  = icseq_pkg::CTL_RST;
        unique case (state_r)
            icseq_pkg::ST_IDLE, icseq_pkg::ST_HOLD: begin
                if (go_rs) begin
                    pin_nxt.scl_oe = 1'b1;
                    state_nxt      = icseq_pkg::ST_RS_SCLL;
                end else if (go_sp) begin
                    pin_nxt.sda_oe = 1'b1;
                    state_nxt      = icseq_pkg::ST_SP_SDAL;
                end else if (go_ack) begin
                    pin_nxt.scl_oe = 1'b1;
                    pin_nxt.sda_oe = !ack_value_bit;
                    ld             = 1'b1;
                    state_nxt      = icseq_pkg::ST_ACK_LO;
                end else if ((state_r == icseq_pkg::ST_IDLE) && byte_done) begin
                    pin_nxt.scl_oe = 1'b1;
                    state_nxt      = icseq_pkg::ST_HOLD;
                end
            end
            icseq_pkg::ST_RS_SCLL: begin
                if (!scl_s) begin
                    ld             = 1'b1;
                    ld_val         = {1'b0, rate_reload_value[icseq_pkg::RS_RATE_W-1:0]};
                    pin_nxt.sda_oe = 1'b0;
                    state_nxt      = icseq_pkg::ST_RS_SDAH;
                end
            end
            icseq_pkg::ST_RS_SDAH: begin
                if (brg_tmo) begin
                    if (sda_s) begin
                        pin_nxt.scl_oe = 1'b0;
                        state_nxt      = icseq_pkg::ST_RS_SCLH;
                    end else begin
                        coll_set  = 1'b1;
                        clr_mask[icseq_pkg::CTL_RESTART] = 1'b1;
                        state_nxt = icseq_pkg::ST_IDLE;
                    end
                end
            end
            icseq_pkg::ST_RS_SCLH: begin
                if (scl_s) begin
                    if (!sda_s) begin
                        coll_set  = 1'b1;
                        clr_mask[icseq_pkg::CTL_RESTART] = 1'b1;
                        state_nxt = icseq_pkg::ST_IDLE;
                    end else begin
                        ld        = 1'b1;
                        state_nxt = icseq_pkg::ST_RS_WAIT;
                    end
                end
            end
            icseq_pkg::ST_RS_WAIT: begin
                if (!scl_s || !sda_s) begin
                    coll_set  = 1'b1;
                    clr_mask[icseq_pkg::CTL_RESTART] = 1'b1;
                    off       = 1'b1;
                    state_nxt = icseq_pkg::ST_IDLE;
                end else if (brg_tmo) begin
                    pin_nxt.sda_oe = 1'b1;
                    ld             = 1'b1;
                    state_nxt      = icseq_pkg::ST_RS_SDAL;
                end
            end
            icseq_pkg::ST_RS_SDAL: begin
                if (brg_tmo) begin
                    clr_mask[icseq_pkg::CTL_RESTART] = 1'b1;
                    evt_set   = 1'b1;
                    off       = 1'b1;
                    state_nxt = icseq_pkg::ST_IDLE;
                end
            end
            icseq_pkg::ST_ACK_LO: begin
                if (brg_tmo) begin
                    pin_nxt.scl_oe = 1'b0;
                    state_nxt      = icseq_pkg::ST_ACK_SCL;
                end
            end
            icseq_pkg::ST_ACK_SCL: begin
                if (scl_s) begin
                    ld        = 1'b1;
                    state_nxt = icseq_pkg::ST_ACK_HI;
                end
            end
            icseq_pkg::ST_ACK_HI: begin
                if (brg_tmo) begin
                    pin_nxt.scl_oe = 1'b1;
                    clr_mask[icseq_pkg::CTL_ACK] = 1'b1;
                    off            = 1'b1;
                    state_nxt      = icseq_pkg::ST_IDLE;
                end
            end
            icseq_pkg::ST_SP_SDAL: begin
                if (!sda_s) begin
                    ld        = 1'b1;
                    state_nxt = icseq_pkg::ST_SP_CNT;
                end
            end
            icseq_pkg::ST_SP_CNT: begin
                if (brg_tmo) begin
                    pin_nxt.scl_oe = 1'b0;
                    ld             = 1'b1;
                    state_nxt      = icseq_pkg::ST_SP_SCL;
                end
            end
            icseq_pkg::ST_SP_SCL: begin
                if (brg_tmo) begin
                    pin_nxt.sda_oe = 1'b0;
                    state_nxt      = icseq_pkg::ST_SP_SDA;
                end
            end
            icseq_pkg::ST_SP_SDA: begin
                if (sda_s && scl_s) begin
                    ld        = 1'b1;
                    state_nxt = icseq_pkg::ST_SP_END;
                end
            end
            icseq_pkg::ST_SP_END: begin
                if (brg_tmo) begin
                    clr_mask[icseq_pkg::CTL_STOP] = 1'b1;
                    evt_set   = 1'b1;
                    off       = 1'b1;
                    state_nxt = icseq_pkg::ST_IDLE;
                end
            end
            default: begin
                pin_nxt   = icseq_pkg::PIN_RST;
                off       = 1'b1;
                state_nxt = icseq_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state and pin drivers.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_r <= icseq_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pin_r <= icseq_pkg::PIN_RST;
        end else begin
            pin_r       <= pin_nxt;
            pin_r.scl_o <= icseq_pkg::DRIVE_LO;
            pin_r.sda_o <= icseq_pkg::DRIVE_LO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits; writes are taken only while no sequence runs.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            serial_control_two_r <= icseq_pkg::CTL_RST;
        end else if (ctl_wr && free) begin
            serial_control_two_r <= ctl_wdata;
        end else begin
            serial_control_two_r <= serial_control_two_r & ~clr_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus condition detection and status flags; a set wins over a clear.
    assign start_seen = sda_prev_r && !sda_s && scl_s && scl_prev_r;
    assign stop_seen  = !sda_prev_r && sda_s && scl_s && scl_prev_r;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sda_prev_r <= icseq_pkg::LINE_RST[0];
            scl_prev_r <= icseq_pkg::LINE_RST[1];
        end else begin
            sda_prev_r <= sda_s;
            scl_prev_r <= scl_s;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stat_r <= icseq_pkg::STAT_RST;
        end else begin
            if (start_seen) begin
                stat_r.start_det <= 1'b1;
                stat_r.stop_det  <= 1'b0;
            end else if (stop_seen) begin
                stat_r.stop_det  <= 1'b1;
                stat_r.start_det <= 1'b0;
            end
            stat_r.event_flag <= evt_set || (stat_r.event_flag && !event_clr);
            stat_r.write_collision_flag       <= (buf_wr && busy) || (stat_r.write_collision_flag && !write_collision_flag_clr);
            stat_r.bus_coll   <= coll_set || (stat_r.bus_coll && !coll_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift buffer; writes during a sequence are dropped.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            shift_buffer_r <= icseq_pkg::BUF_RST;
        end else if (buf_wr && !busy) begin
            shift_buffer_r <= buf_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    restart_from_idle_a: assert property (
        go_rs |=> pin_r.scl_oe && (state_r == icseq_pkg::ST_RS_SCLL))
        else $error("restart did not drive SCL low");
    restart_ignored_a: assert property (
        ctl_wr && ctl_wdata[icseq_pkg::CTL_RESTART] && !free && !serial_control_two_r[icseq_pkg::CTL_RESTART]
        |=> !serial_control_two_r[icseq_pkg::CTL_RESTART])
        else $error("restart taken while busy");
    short_reload_a: assert property (
        (state_r == icseq_pkg::ST_RS_SCLL) && !scl_s
        |=> brg_run && (brg_cnt == {1'b0, $past(rate_reload_value[icseq_pkg::RS_RATE_W-1:0])}))
        else $error("restart reload value wrong");
    scl_release_a: assert property (
        (state_r == icseq_pkg::ST_RS_SDAH) && brg_tmo && sda_s |=> !pin_r.scl_oe && !pin_r.sda_oe)
        else $error("SCL not released after SDA high period");
    restart_coll_a: assert property (
        (state_r == icseq_pkg::ST_RS_SCLH) && scl_s && !sda_s
        |=> stat_r.bus_coll && (state_r == icseq_pkg::ST_IDLE))
        else $error("restart collision missed");
    restart_end_a: assert property (
        (state_r == icseq_pkg::ST_RS_SDAL) && brg_tmo
        |=> !serial_control_two_r[icseq_pkg::CTL_RESTART] && pin_r.sda_oe && stat_r.event_flag)
        else $error("restart did not finish");
    buffer_guard_a: assert property (
        buf_wr && busy |=> stat_r.write_collision_flag && (shift_buffer_r == $past(shift_buffer_r)))
        else $error("buffer written during sequence");
    write_collision_flag_sticky_a: assert property (
        stat_r.write_collision_flag && !write_collision_flag_clr |=> stat_r.write_collision_flag)
        else $error("write collision lost");
    ack_drive_a: assert property (
        go_ack && !go_rs && !go_sp |=> pin_r.scl_oe && (pin_r.sda_oe == !$past(ack_value_bit)))
        else $error("ack value not driven");
    ack_end_a: assert property (
        (state_r == icseq_pkg::ST_ACK_HI) && brg_tmo
        |=> !serial_control_two_r[icseq_pkg::CTL_ACK] && pin_r.scl_oe && !brg_run)
        else $error("ack did not finish");
    stop_end_a: assert property (
        (state_r == icseq_pkg::ST_SP_END) && brg_tmo
        |=> !serial_control_two_r[icseq_pkg::CTL_STOP] && stat_r.event_flag && (state_r == icseq_pkg::ST_IDLE))
        else $error("stop did not finish");
    hold_scl_a: assert property (
        (state_r == icseq_pkg::ST_HOLD) |-> pin_r.scl_oe)
        else $error("SCL not held low after byte");
    restart_done_c: cover property ((state_r == icseq_pkg::ST_RS_SDAL) && brg_tmo);
    ack_done_c: cover property ((state_r == icseq_pkg::ST_ACK_HI) && brg_tmo);
    stop_done_c: cover property ((state_r == icseq_pkg::ST_SP_END) && brg_tmo);
    collision_c: cover property (coll_set);
endmodule

// *** design/icseq_pkg.sv ***
package icseq_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths.
    localparam int RATE_W    = 7;
    localparam int RS_RATE_W = 6;
    localparam int CTL_W     = 5;
    localparam int BUF_W     = 8;
    localparam int PIN_N     = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Positions in the low five bits of serial_control_two.
    localparam int CTL_START   = 0;
    localparam int CTL_RESTART = 1;
    localparam int CTL_STOP    = 2;
    localparam int CTL_RCV     = 3;
    localparam int CTL_ACK     = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [CTL_W-1:0]  CTL_RST  = 5'h00;
    localparam logic [BUF_W-1:0]  BUF_RST  = 8'h00;
    localparam logic [RATE_W-1:0] CNT_RST  = 7'h00;
    localparam logic [PIN_N-1:0]  LINE_RST = 2'h3;
    localparam logic              DRIVE_LO = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer states, Gray coded along each sequence.
    typedef enum logic [3:0] {
        ST_IDLE    = 4'h0,
        ST_RS_SCLL = 4'h1,
        ST_RS_SDAH = 4'h3,
        ST_RS_SCLH = 4'h2,
        ST_RS_WAIT = 4'h6,
        ST_RS_SDAL = 4'h7,
        ST_ACK_LO  = 4'h5,
        ST_ACK_SCL = 4'h4,
        ST_ACK_HI  = 4'hC,
        ST_HOLD    = 4'hD,
        ST_SP_SDAL = 4'hF,
        ST_SP_CNT  = 4'hE,
        ST_SP_SCL  = 4'hA,
        ST_SP_SDA  = 4'hB,
        ST_SP_END  = 4'h9
    } icseq_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } icseq_pin_t;

    typedef struct packed {
        logic start_det;
        logic stop_det;
        logic event_flag;
        logic write_collision_flag;
        logic bus_coll;
    } icseq_stat_t;

    localparam icseq_pin_t  PIN_RST  = 4'h0;
    localparam icseq_stat_t STAT_RST = 5'h00;

endpackage

// *** design/icseq_sync.sv ***
`timescale 1ns/1ns
module icseq_sync (
    // Clock and reset.
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    // Raw lines and filtered levels.
    input  wire logic [icseq_pkg::PIN_N-1:0]   line_i,
    output logic      [icseq_pkg::PIN_N-1:0]   lvl_o
);

    logic [icseq_pkg::PIN_N-1:0] ff1_r;
    logic [icseq_pkg::PIN_N-1:0] ff2_r;
    logic [icseq_pkg::PIN_N-1:0] ff3_r;

    ////////////////////////////////////////////////////////////////////////////
    // Three stages; a level counts once stages two and three agree.
    genvar g;
    generate
        for (g = 0; g < icseq_pkg::PIN_N; g++) begin : g_line
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    ff1_r[g] <= icseq_pkg::LINE_RST[g];
                    ff2_r[g] <= icseq_pkg::LINE_RST[g];
                    ff3_r[g] <= icseq_pkg::LINE_RST[g];
                    lvl_o[g] <= icseq_pkg::LINE_RST[g];
                end else begin
                    ff1_r[g] <= line_i[g];
                    ff2_r[g] <= ff1_r[g];
                    ff3_r[g] <= ff2_r[g];
                    if (ff2_r[g] == ff3_r[g]) begin
                        lvl_o[g] <= ff3_r[g];
                    end
                end
            end
        end
    endgenerate

endmodule

// *** sim/i2c_master_condition_sequencer_tb.sv ***
`timescale 1ns/1ns
module i2c_master_condition_sequencer_tb;
    logic clk_sys = 0, rst_b = 0, ctl_wr = 0, ack_value_bit = 0, buf_wr = 0, event_clr = 0;
    logic write_collision_flag_clr = 0, coll_clr = 0, xfer_busy = 0, byte_done = 0, stretch = 1, jam = 0, scl, sda;
    logic [4:0] ctl_wdata = 5'h00, ctl_q;
    logic [6:0] rate = 7'h05;
    logic [7:0] buf_wdata = 8'h00, buf_q, rnd = 8'h25, buf_e = 8'h00;
    icseq_pkg::icseq_pin_t  pin_r;
    icseq_pkg::icseq_stat_t stat_r;
    int bad_count = 0, n_compared = 0, cyc = 0;
    logic [21:0] exp_q[$];
    event seen;
    icseq_core icseq_core_inst (.clk_sys(clk_sys), .rst_b(rst_b), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
        .ack_value_bit(ack_value_bit), .rate_reload_value(rate), .buf_wr(buf_wr), .buf_wdata(buf_wdata),
        .event_clr(event_clr), .write_collision_flag_clr(write_collision_flag_clr), .coll_clr(coll_clr), .xfer_busy(xfer_busy),
        .byte_done(byte_done), .scl_i(scl), .sda_i(sda), .pin_r(pin_r), .serial_control_two_r(ctl_q),
        .stat_r(stat_r), .shift_buffer_r(buf_q));
    icseq_bus_model icseq_bus_model_inst (.clk_sys(clk_sys), .scl_oe(pin_r.scl_oe), .sda_oe(pin_r.sda_oe),
        .stretch(stretch), .jam(jam), .scl(scl), .sda(sda));
    initial forever #25 clk_sys = ~clk_sys;
    function automatic logic [7:0] nxt(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic chk(string n, logic [21:0] e, logic [21:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic note(logic [21:0] e);
        exp_q.push_back(e);
        -> seen;
    endtask
    // Watches the outputs and compares them with the oldest note.
    always @(seen) begin
        chk("status", exp_q.pop_front(), {ctl_q, stat_r, buf_q, pin_r});
    end
    task automatic wr_ctl(logic [4:0] v);
        ctl_wdata = v;
        ctl_wr = 1;
        @(negedge clk_sys) ctl_wr = 0;
    endtask
    task automatic wr_buf(logic [7:0] v);
        buf_wdata = v;
        buf_wr = 1;
        @(negedge clk_sys) buf_wr = 0;
    endtask
    task automatic clr();
        {event_clr, write_collision_flag_clr, coll_clr} = 3'h7;
        @(negedge clk_sys) {event_clr, write_collision_flag_clr, coll_clr} = 3'h0;
    endtask
    task automatic wait_clear(int b);
        int k;
        k = 0;
        while (ctl_q[b] !== 1'b0 && k < 400) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 400) bad_count++;
    endtask
    task automatic report_and_stop();
        if (bad_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        rst_b = 1;
        note(22'h0);
        rnd = nxt(rnd);
        wr_buf(rnd);
        note({10'h000, rnd, 4'h0});
        wr_ctl(5'h02);
        repeat (2) @(negedge clk_sys);
        wr_buf(~rnd);
        wr_ctl(5'h04);
        wait_clear(1);
        note({5'h00, 5'b10110, rnd, 4'h1});
        clr();
        rnd = nxt(rnd);
        wr_buf(rnd);
        buf_e = rnd;
        note({5'h00, 5'b10000, buf_e, 4'h1});
        ack_value_bit = rnd[0];
        wr_ctl(5'h10);
        note({5'h10, 5'b10000, buf_e, 3'b010, !rnd[0]});
        wr_buf(8'hA5);
        wait_clear(4);
        note({5'h00, 5'b10010, buf_e, 3'b010, !rnd[0]});
        byte_done = 1;
        @(negedge clk_sys) byte_done = 0;
        // The stop releases SDA a fixed period after SCL, so no slave stretches here.
        stretch = 0;
        wr_ctl(5'h04);
        wr_buf(8'h3C);
        wait_clear(2);
        stretch = 1;
        note({5'h00, 5'b01110, buf_e, 4'h0});
        clr();
        xfer_busy = 1;
        wr_ctl(5'h02);
        note({5'h00, 5'b01000, buf_e, 4'h0});
        xfer_busy = 0;
        @(negedge clk_sys);
        wr_ctl(5'h02);
        // SDA is jammed while the slave stretches SCL, so SDA is low as SCL rises.
        repeat (12) @(negedge clk_sys);
        jam = 1;
        wait_clear(1);
        note({5'h00, 5'b01001, buf_e, 4'h0});
        jam = 0;
        repeat (2) @(negedge clk_sys);
        report_and_stop();
    end
endmodule

// *** sim/icseq_bus_model.sv ***
`timescale 1ns/1ns
// Far side of the bus: pull-ups, a slave that stretches SCL and a master that jams SDA.
module icseq_bus_model (
    // Clock.
    input  wire logic clk_sys,
    // Device drives and test controls.
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic stretch,
    input  wire logic jam,
    // Wire levels.
    output logic      scl,
    output logic      sda
);
    logic [3:0] hold_r = 4'h0;
    logic       oe_r   = 1'b0;
    always_ff @(posedge clk_sys) begin
        oe_r   <= scl_oe;
        hold_r <= (oe_r && !scl_oe && stretch) ? 4'h8 : hold_r - 4'(hold_r != 4'h0);
    end
    assign scl = !(scl_oe || (oe_r && stretch) || hold_r != 4'h0);
    assign sda = !(sda_oe || jam);
endmodule
